/* File: verilog/hdp_pkg.sv */
// shared constants and types for the host data port handshake block
package hdp_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ    = 100_000_000; // core clock rate
  localparam int              RESP_US   = 10;          // longest grant / release answer, microseconds
  localparam int              TIMEOUT_S = 21;          // remote silence before a timeout report, seconds
  localparam int              MAX_BUF   = 7;           // buffers queued per direction
  // ---------------------------------------------------------------
  // byte registers of the host port
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_IN_CTRL  = 3'h0;          // input control byte
  localparam logic [2:0] REG_MAINT    = 3'h1;          // maintenance byte
  localparam logic [2:0] REG_OUT_CTRL = 3'h2;          // output control byte
  localparam int         DATA_SEL_BIT = 2;             // byte index bit that selects the data port bytes
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_IO    = 2;                        // direction bit of a type or format code
  localparam int BIT_RQI   = 5;                        // input_request
  localparam int BIT_IE    = 6;                        // input_irq_enable / output_irq_enable
  localparam int BIT_RDY   = 7;                        // input_granted / output_pending
  localparam int BIT_MCLR  = 6;                        // master clear in the maintenance byte
  localparam int HI_LSB    = 16;                       // first bit of the high data word
  localparam int BIT_HD    = 10;                       // half_duplex_select in the high word
  localparam int BIT_SEC   = 11;                       // secondary_role_select in the high word
  localparam int BIT_RES   = 13;                       // resume flag in the high word
  localparam int ADDR_HI   = 14;                       // address bits 17:16 sit at high word 15:14
  // control-out condition bits
  localparam int CO_RETRY  = 0;                        // retry_threshold_flag
  localparam int CO_TMO    = 1;                        // remote silence
  localparam int CO_NOBUF  = 2;                        // no_buffer_flag
  localparam int CO_MAINT  = 3;                        // maint_msg_flag
  localparam int CO_LOST   = 4;                        // message longer than buffer
  localparam int CO_DSR    = 6;                        // data set ready came on
  localparam int CO_START  = 7;                        // remote_restart_flag
  localparam int CO_BUSTO  = 8;                        // bus_timeout_flag
  localparam int CO_PROC   = 9;                        // host_procedure_flag
  localparam int CO_W      = 10;                       // width of the condition set
  // ---------------------------------------------------------------
  // transfer codes
  // ---------------------------------------------------------------
  localparam logic [1:0] TYPE_BUF  = 2'h0;             // buffer address / count
  localparam logic [1:0] TYPE_CTL  = 2'h1;             // control in
  localparam logic [1:0] TYPE_BAD  = 2'h2;             // undefined code
  localparam logic [1:0] TYPE_BASE = 2'h3;             // table_base_input
  localparam logic [2:0] OUT_CTL   = 3'h1;             // control-out format
  localparam logic [2:0] OUT_BUF   = 3'h0;             // buffer return format, io bit added
  // data port ownership
  typedef enum logic [1:0] {
    PORT_FREE = 2'b00,
    PORT_IN   = 2'b01,
    PORT_OUT  = 2'b10
  } hdp_port_t;
endpackage : hdp_pkg

/* File: verilog/hdp_top.sv */
// host data port: request/grant input transfers, output transfers, control-out reporting
`timescale 1ns/1ps
// Summary of operation
// [RL1] flag timeout after 21 seconds remote silence
// [RL2] flag no-buffer arrival and overlong message
// [RL3] flag maintenance message and restart message
// [RL4] flag data-set-ready rising; bit 5 reserved
// [RL5] flag bus timeout and host procedure error
// [RL6] host writes type and request together
// [RL7] grant port by setting input granted
// [RL8] host loads data, drops request; device completes
// [RL9] release grant within 10 us; host waits
// [RL10] answer request within 10 microseconds
// [RL11] input interrupt while enabled and granted
// [RL12] withhold buffer grant at seven queued
// [RL13] output only when port is free
// [RL14] no output transfer until reinitialized
// [RL15] load data, format code, then pending flag
// [RL16] host reads data then clears pending
// [RL17] output interrupt while enabled and pending
// [RL18] reset, bus init, master clear restart all; clr spares synchronisers, in_type_o, in_data_o, read/irq/status registers
// [RL19] host initializes with base input, resume
// [RL20] base table owned by device afterwards
// [RL21] control in selects half duplex, role
// [RL22] answer start; initiate after transmit buffer
// [RL23] control-out format: bit1 clear, bit0 set
// [RL24] conditions placed in high data word
module hdp_top
  import hdp_pkg::*;
#(
  parameter int          MAX_BUF_P   = hdp_pkg::MAX_BUF,                  // queue limit per direction
  parameter logic [31:0] TIMEOUT_CYC = 32'(longint'(hdp_pkg::TIMEOUT_S) * hdp_pkg::CLK_HZ) // silence cycles
) (
  input  wire logic        clock_i,           // core clock
  input  wire logic        rstn_i,            // power-up reset
  input  wire logic        bus_init_i,        // system bus init, asynchronous
  input  wire logic [2:0]  host_addr_i,       // byte register index
  input  wire logic        host_wr_i,         // byte write strobe
  input  wire logic [7:0]  host_wdata_i,      // write byte
  output logic      [7:0]  host_rdata_o,      // read byte, one cycle after address
  output logic             irq_in_o,          // input vector request
  output logic             irq_out_o,         // output vector request
  input  wire logic        dsr_i,             // modem data set ready pin
  input  wire logic        remote_activity_i, // pulse: something heard from remote end
  input  wire logic        evt_retry_i,       // pulse: retransmit threshold passed
  input  wire logic        evt_no_buf_i,      // pulse: message with no receive buffer
  input  wire logic        evt_maint_i,       // pulse: maintenance message taken
  input  wire logic        evt_lost_i,        // pulse: message longer than buffer
  input  wire logic        evt_start_i,       // pulse: start message while running
  input  wire logic        evt_bus_to_i,      // pulse: bus address timeout
  input  wire logic        ret_valid_i,       // buffer return waiting
  input  wire logic        ret_rx_i,          // returned buffer is a receive buffer
  input  wire logic [31:0] ret_data_i,        // returned address and count
  output logic             ret_ack_o,         // pulse: return taken
  output logic             in_done_o,         // pulse: input transfer finished
  output logic      [2:0]  in_type_o,         // type of the finished transfer
  output logic      [31:0] in_data_o,         // data of the finished transfer
  output logic      [17:0] base_addr_o,       // table address
  output logic             initialized_o,     // base input taken
  output logic             half_duplex_o,     // half duplex selected
  output logic             secondary_o,       // secondary role, 3 s retransmit timer
  output logic             answer_start_o,    // respond to remote start
  output logic             may_initiate_o     // allowed to open start sequence
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  localparam int CW       = $clog2(MAX_BUF_P + 1);                    // queue counter width
  localparam int RESP_CYC = int'(RESP_US * (CLK_HZ / 1_000_000));     // answer bound in cycles
  if (MAX_BUF_P < 1 || MAX_BUF_P > 255) begin : g_chk_buf
    $error("queue limit out of range");
  end
  if (TIMEOUT_CYC < 32'h2) begin : g_chk_tmo
    $error("timeout count too small");
  end
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  hdp_port_t         port;        // data port owner
  logic [2:0]        in_type;     // input_type_code
  logic              input_request;         // input_request
  logic              input_irq_enable;         // input_irq_enable
  logic [2:0]        out_code;    // output format code
  logic              output_irq_enable;         // output_irq_enable
  logic [31:0]       data;        // data_port_bytes
  logic [CO_W-1:0]   cond;        // pending control-out conditions
  logic [CO_W-1:0]   evt;         // this cycle's condition events
  logic [CW-1:0]     tx_cnt;      // transmit buffers held
  logic [CW-1:0]     rx_cnt;      // receive buffers held
  logic              resume;      // resume flag of the last base input
  logic [31:0]       tmo_cnt;     // silence counter
  logic              tmo_evt;     // silence limit reached
  logic              dsr_m;       // synchroniser first stage
  logic              dsr_s;       // synchronised level
  logic              dsr_d;       // previous level
  logic              init_m;      // synchroniser first stage
  logic              init_s;      // synchronised bus init
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic wr_in, wr_out, wr_data, clr;
  logic is_buf, full, bad, req_new, proc_hit, grant, in_end;
  logic can_out, ret_take, ctl_take, out_end;
  logic [CW-1:0] max_cnt;
  assign max_cnt  = CW'(MAX_BUF_P);
  assign wr_in    = host_wr_i && (host_addr_i == REG_IN_CTRL);
  assign wr_out   = host_wr_i && (host_addr_i == REG_OUT_CTRL);
  assign wr_data  = host_wr_i && host_addr_i[DATA_SEL_BIT];
  // master clear restarts the control state synchronously; synchronisers, in_type_o, in_data_o and read/irq/status registers keep running
  assign clr      = init_s || (host_wr_i && (host_addr_i == REG_MAINT) && host_wdata_i[BIT_MCLR]); // RL18
  assign is_buf   = (in_type[1:0] == TYPE_BUF);
  assign full     = in_type[BIT_IO] ? (rx_cnt == max_cnt) : (tx_cnt == max_cnt);
  // buffer before base, base twice, or an undefined code cannot be honoured
  assign bad      = (in_type[1:0] == TYPE_BAD) || (is_buf && !initialized_o)
                 || ((in_type[1:0] == TYPE_BASE) && initialized_o);
  assign req_new  = (port == PORT_FREE) && input_request;
  assign proc_hit = req_new && bad;                                     // RL5
  assign grant    = req_new && !bad && !(is_buf && full);               // RL7 RL10 RL12
  assign in_end   = (port == PORT_IN) && !input_request;                          // RL8
  // output may only seize a free port that is not being granted
  assign can_out  = (port == PORT_FREE) && !grant && initialized_o;     // RL13 RL14
  assign ret_take = can_out && ret_valid_i && !ret_ack_o;
  assign ctl_take = can_out && !ret_take && (cond != '0);
  assign out_end  = (port == PORT_OUT) && wr_out && !host_wdata_i[BIT_RDY]; // RL16
  // ---------------------------------------------------------------
  // synchronisers for pins
  // ---------------------------------------------------------------
  // first stages are read only by the second stages
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dsr_m  <= 1'b0;
      dsr_s  <= 1'b0;
      dsr_d  <= 1'b0;
      init_m <= 1'b0;
      init_s <= 1'b0;
    end else begin
      dsr_m  <= dsr_i;
      dsr_s  <= dsr_m;
      dsr_d  <= dsr_s;
      init_m <= bus_init_i;
      init_s <= init_m;
    end
  end
  // ---------------------------------------------------------------
  // input control byte
  // ---------------------------------------------------------------
  // a host write beats the device dropping a refused request
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_type <= 3'h0;
      input_request     <= 1'b0;
      input_irq_enable     <= 1'b0;
    end else if (clr) begin
      in_type <= 3'h0;
      input_request     <= 1'b0;
      input_irq_enable     <= 1'b0;
    end else if (wr_in) begin
      in_type <= host_wdata_i[2:0];      // RL6
      input_request     <= host_wdata_i[BIT_RQI];  // RL6
      input_irq_enable     <= host_wdata_i[BIT_IE];
    end else if (proc_hit) begin
      input_request     <= 1'b0;                   // refused request is withdrawn so it is not reported twice
    end
  end
  // ---------------------------------------------------------------
  // port ownership
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port <= PORT_FREE;
    end else if (clr) begin
      port <= PORT_FREE;
    end else begin
      unique case (port)
        PORT_FREE: begin
          if (grant) begin
            port <= PORT_IN;             // RL7
          end else if (ret_take || ctl_take) begin
            port <= PORT_OUT;            // RL15
          end
        end
        PORT_IN: begin
          if (in_end) begin
            port <= PORT_FREE;           // RL8 RL9
          end
        end
        PORT_OUT: begin
          if (out_end) begin
            port <= PORT_FREE;
          end
        end
        default: begin
          port <= PORT_FREE;             // unused code falls back to free
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // output control byte and data port
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_code <= 3'h0;
      output_irq_enable      <= 1'b0;
    end else if (clr) begin
      out_code <= 3'h0;
      output_irq_enable      <= 1'b0;
    end else begin
      if (wr_out) begin
        output_irq_enable <= host_wdata_i[BIT_IE];
      end
      if (ret_take) begin
        out_code <= OUT_BUF | {ret_rx_i, 2'b00};  // RL15
      end else if (ctl_take) begin
        out_code <= OUT_CTL;                      // RL23
      end
    end
  end
  // host bytes are only accepted while the port is granted to it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data <= 32'h0;
    end else if (clr) begin
      data <= 32'h0;
    end else if (ret_take) begin
      data <= ret_data_i;                         // RL15
    end else if (ctl_take) begin
      data <= {6'h0, cond, 16'h0};                // RL24
    end else if (wr_data && (port == PORT_IN)) begin
      data[{host_addr_i[1:0], 3'b000} +: 8] <= host_wdata_i;
    end
  end
  // ---------------------------------------------------------------
  // control-out conditions
  // ---------------------------------------------------------------
  always_comb begin
    evt           = '0;
    evt[CO_RETRY] = evt_retry_i;
    evt[CO_TMO]   = tmo_evt;                      // RL1
    evt[CO_NOBUF] = evt_no_buf_i;                 // RL2
    evt[CO_LOST]  = evt_lost_i;                   // RL2
    evt[CO_MAINT] = evt_maint_i;                  // RL3
    evt[CO_START] = evt_start_i;                  // RL3
    evt[CO_DSR]   = dsr_s && !dsr_d;              // RL4
    evt[CO_BUSTO] = evt_bus_to_i;                 // RL5
    evt[CO_PROC]  = proc_hit;                     // RL5
  end
  // taken conditions clear, but an event in the same cycle stays set
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cond <= '0;
    end else if (clr) begin
      cond <= '0;
    end else begin
      cond <= (ctl_take ? '0 : cond) | evt;
    end
  end
  // ---------------------------------------------------------------
  // remote silence timer
  // ---------------------------------------------------------------
  // runs only once initialized; limit is a parameter so simulation can shorten it
  assign tmo_evt = initialized_o && !remote_activity_i && (tmo_cnt == TIMEOUT_CYC - 32'h1);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmo_cnt <= 32'h0;
    end else if (clr || !initialized_o || remote_activity_i || tmo_evt) begin
      tmo_cnt <= 32'h0;                           // RL1
    end else begin
      tmo_cnt <= tmo_cnt + 32'h1;
    end
  end
  // ---------------------------------------------------------------
  // queued buffer counts
  // ---------------------------------------------------------------
  logic inc_tx, inc_rx, dec_tx, dec_rx;
  assign inc_tx = in_end && is_buf && !in_type[BIT_IO];
  assign inc_rx = in_end && is_buf && in_type[BIT_IO];
  // a return with nothing queued must not wrap the count up to the limit
  assign dec_tx = ret_take && !ret_rx_i && (tx_cnt != '0);
  assign dec_rx = ret_take && ret_rx_i && (rx_cnt != '0);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else if (clr) begin
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else begin
      tx_cnt <= tx_cnt + CW'(inc_tx) - CW'(dec_tx);  // RL12
      rx_cnt <= rx_cnt + CW'(inc_rx) - CW'(dec_rx);  // RL12
    end
  end
  // ---------------------------------------------------------------
  // completion of input transfers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      initialized_o <= 1'b0;
      base_addr_o   <= 18'h0;
      resume        <= 1'b0;
      half_duplex_o <= 1'b0;
      secondary_o   <= 1'b0;
    end else if (clr) begin
      initialized_o <= 1'b0;                      // RL14 RL18 RL20
      base_addr_o   <= 18'h0;
      resume        <= 1'b0;
      half_duplex_o <= 1'b0;
      secondary_o   <= 1'b0;
    end else if (in_end && (in_type[1:0] == TYPE_BASE)) begin
      initialized_o <= 1'b1;                      // RL19
      base_addr_o   <= {data[HI_LSB+ADDR_HI +: 2], data[HI_LSB-1:0]};
      resume        <= data[HI_LSB+BIT_RES];      // RL19
    end else if (in_end && (in_type[1:0] == TYPE_CTL)) begin
      half_duplex_o <= data[HI_LSB+BIT_HD];       // RL21
      secondary_o   <= data[HI_LSB+BIT_SEC];      // RL21
    end
  end
  // hand the finished transfer to the protocol engine
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_done_o <= 1'b0;
      in_type_o <= 3'h0;
      in_data_o <= 32'h0;
    end else begin
      in_done_o <= in_end && !clr;
      if (in_end) begin
        in_type_o <= in_type;
        in_data_o <= data;
      end
    end
  end
  // ---------------------------------------------------------------
  // host read, interrupts and status outputs
  // ---------------------------------------------------------------
  // level interrupts, so enabling after the flag is up still interrupts
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_rdata_o   <= 8'h0;
      irq_in_o       <= 1'b0;
      irq_out_o      <= 1'b0;
      ret_ack_o      <= 1'b0;
      answer_start_o <= 1'b0;
      may_initiate_o <= 1'b0;
    end else begin
      unique case (host_addr_i)
        REG_IN_CTRL:  host_rdata_o <= {port == PORT_IN, input_irq_enable, input_request, 2'b00, in_type};
        REG_OUT_CTRL: host_rdata_o <= {port == PORT_OUT, output_irq_enable, 3'b000, out_code};
        3'h4, 3'h5, 3'h6, 3'h7: host_rdata_o <= data[{host_addr_i[1:0], 3'b000} +: 8];
        default:      host_rdata_o <= 8'h0;       // maintenance byte and hole read zero
      endcase
      irq_in_o       <= input_irq_enable && (port == PORT_IN);               // RL11
      irq_out_o      <= output_irq_enable && (port == PORT_OUT);              // RL17
      ret_ack_o      <= ret_take;
      answer_start_o <= initialized_o && !resume;               // RL22
      may_initiate_o <= initialized_o && !resume && (tx_cnt != '0); // RL22
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i || clr);
  AST_GRANT_ANSWER: assert property (input_request && port == PORT_FREE && !bad && !(is_buf && full) // RL10
    |=> port == PORT_IN) else $error("request not granted");
  AST_RELEASE: assert property (port == PORT_IN && !input_request |-> ##[1:RESP_CYC] port != PORT_IN) // RL9
    else $error("grant not released in time");
  AST_FULL_HOLD: assert property (port == PORT_FREE && input_request && is_buf && full && !bad // RL12
    |=> port != PORT_IN) else $error("grant beyond queue limit");
  AST_OUT_EXCL: assert property (port == PORT_IN |=> port != PORT_OUT) // RL13
    else $error("output seized a granted port");
  AST_UNINIT: assert property (!initialized_o |=> port != PORT_OUT) // RL14
    else $error("output before initialization");
  AST_CTL_FMT: assert property (ctl_take |=> out_code == OUT_CTL && port == PORT_OUT // RL23
    && data[31:16] == {6'h0, $past(cond)}) else $error("control-out format wrong");
  AST_IRQ_IN: assert property (input_irq_enable && port == PORT_IN |=> irq_in_o) // RL11
    else $error("input interrupt missing");
  AST_IRQ_OUT: assert property (output_irq_enable && port == PORT_OUT |=> irq_out_o) // RL17
    else $error("output interrupt missing");
  AST_DSR_FLAG: assert property (dsr_s && !dsr_d |=> cond[CO_DSR]) // RL4
    else $error("data set ready edge lost");
  AST_RSVD: assert property (!cond[5]) else $error("reserved condition set"); // RL4
  AST_TMO_FLAG: assert property (tmo_evt |=> cond[CO_TMO]) // RL1
    else $error("timeout not flagged");
  AST_PROC_FLAG: assert property (proc_hit |=> cond[CO_PROC] && port != PORT_IN) // RL5
    else $error("procedure error not flagged");
  AST_NOBUF_FLAG: assert property (evt_no_buf_i |=> cond[CO_NOBUF]) // RL2
    else $error("no-buffer arrival lost");
  AST_LOST_FLAG: assert property (evt_lost_i |=> cond[CO_LOST]) // RL2
    else $error("overlong message lost");
  COV_GRANT: cover property (grant ##1 port == PORT_IN ##[1:20] in_end);
  COV_CTL: cover property (ctl_take ##[1:20] out_end);
  COV_FULL: cover property (input_request && is_buf && full && port == PORT_FREE);
endmodule : hdp_top

/* File: testbench/hdp_ret_model.sv */
// buffer return source on the line side of the host data port
`timescale 1ns/1ps
module hdp_ret_model (
  input  wire logic        clock_i,     // core clock
  input  wire logic        rstn_i,      // async reset, active low
  input  wire logic        go_i,        // queue one receive-buffer return
  input  wire logic        ret_ack_i,   // return taken by the port
  output logic             ret_valid_o, // return waiting
  output logic             ret_rx_o,    // always a receive buffer here
  output logic      [31:0] ret_data_o   // address and count image
);
  // hold the return until taken; data inverted afterwards so stale data never looks valid
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ret_valid_o <= 1'b0;
      ret_data_o  <= 32'h0000_0000;
    end else if (go_i) begin
      ret_valid_o <= 1'b1;
      ret_data_o  <= 32'hA5C3_1234;
    end else if (ret_ack_i) begin
      ret_valid_o <= 1'b0;
      ret_data_o  <= ~ret_data_o;
    end
  end
  assign ret_rx_o = 1'b1;
endmodule : hdp_ret_model

/* File: testbench/hdp_top_tb.sv */
// self-checking bench for the host data port handshake block
`timescale 1ns/1ps
module hdp_top_tb;
  import hdp_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, act = 1'b1, go = 1'b0;
  logic [2:0]  a = 3'h0;
  logic [7:0]  wd = 8'h00, rd;
  logic [6:0]  ev = 7'h00; // event pulses; bit 6 drives the data set ready pin
  logic        rv, rrx, rack, irqi, irqo, init, idone, hd, sec, astart, minit;
  logic        binit = 1'b0;
  logic [2:0]  itype;
  logic [31:0] rdat, idat;
  logic [17:0] base;
  int          err_total = 0, tests_run = 0, ndone = 0;
  int          pos[7] = '{0, 2, 3, 4, 7, 8, 6}; // condition bit of each event pulse
  always #5 clk = ~clk;
  // finished input transfers, counted while each pulse stands
  always @(posedge clk) if (idone) ndone <= ndone + 1;
  hdp_ret_model prt (.clock_i(clk), .rstn_i(rstn), .go_i(go), .ret_ack_i(rack), .ret_valid_o(rv),
    .ret_rx_o(rrx), .ret_data_o(rdat));
  hdp_top #(.TIMEOUT_CYC(32'hC8)) uut (.clock_i(clk), .rstn_i(rstn), .bus_init_i(binit), .host_addr_i(a),
    .host_wr_i(wr), .host_wdata_i(wd), .host_rdata_o(rd), .irq_in_o(irqi), .irq_out_o(irqo), .dsr_i(ev[6]),
    .remote_activity_i(act), .evt_retry_i(ev[0]), .evt_no_buf_i(ev[1]), .evt_maint_i(ev[2]), .evt_lost_i(ev[3]),
    .evt_start_i(ev[4]), .evt_bus_to_i(ev[5]), .ret_valid_i(rv), .ret_rx_i(rrx), .ret_data_i(rdat),
    .ret_ack_o(rack), .in_done_o(idone), .in_type_o(itype), .in_data_o(idat), .base_addr_o(base),
    .initialized_o(init), .half_duplex_o(hd), .secondary_o(sec), .answer_start_o(astart), .may_initiate_o(minit));
  task automatic end_of_test();
    $display("Mismatches %0d of %0d compares", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one byte write, strobe high for exactly one edge
  task automatic wrb(input logic [2:0] x, input logic [7:0] d);
    @(posedge clk) begin a <= x; wd <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wrb
  // read data lags the address by one cycle
  task automatic rdb(input logic [2:0] x, input logic [7:0] exp);
    @(posedge clk) a <= x;
    @(posedge clk) #1 chk(rd, exp);
  endtask : rdb
  // 1000 cycles is the 10 us answer limit at 100 MHz
  task automatic wt(input logic [2:0] x, input int b, input logic v);
    int n;
    n = 0;
    @(posedge clk) a <= x;
    @(posedge clk) #1;
    while (rd[b] !== v && n < 1000) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 1000) begin err_total++; end_of_test(); end
  endtask : wt
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdb(3'h0, 8'h00);
    wrb(3'h0, 8'h20);
    repeat (4) @(posedge clk);
    rdb(3'h0, 8'h00);
    rdb(3'h2, 8'h00);
    wrb(3'h0, 8'h63);
    wt(3'h0, 7, 1'b1);
    rdb(3'h0, 8'hE3);
    chk(irqi, 1'b1);
    wrb(3'h4, 8'h00);
    wrb(3'h5, 8'h12);
    wrb(3'h6, 8'h00);
    wrb(3'h7, 8'hC0);
    wrb(3'h0, 8'h43);
    wt(3'h0, 7, 1'b0);
    repeat (2) @(posedge clk);
    chk({init, base}, {1'b1, 18'h31200});
    chk(idat, 32'hC000_1200);
    chk({itype, astart}, 4'h7);
    wt(3'h2, 7, 1'b1);
    rdb(3'h2, 8'h81);
    rdb(3'h7, 8'h02);
    wrb(3'h2, 8'h40);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    wt(3'h2, 7, 1'b1);
    rdb(3'h2, 8'hC4);
    rdb(3'h4, 8'h34);
    chk(irqo, 1'b1);
    wrb(3'h2, 8'h40);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) ev <= 7'(1 << i);
      @(posedge clk) ev <= 7'h00;
      wt(3'h2, 7, 1'b1);
      rdb(3'h6, 8'((1 << pos[i]) & 8'hFF));
      rdb(3'h7, 8'((1 << pos[i]) >> 8));
      wrb(3'h2, 8'h40);
    end
    wrb(3'h0, 8'h21);
    wt(3'h0, 7, 1'b1);
    wrb(3'h6, 8'h00);
    wrb(3'h7, 8'h0C);
    wrb(3'h0, 8'h01);
    wt(3'h0, 7, 1'b0);
    chk({itype, hd, sec}, 5'h07);
    for (int i = 0; i < 7; i++) begin
      wrb(3'h0, 8'h20);
      wt(3'h0, 7, 1'b1);
      wrb(3'h0, 8'h00);
      wt(3'h0, 7, 1'b0);
    end
    wrb(3'h0, 8'h20);
    rdb(3'h0, 8'h20);
    wrb(3'h0, 8'h00);
    chk(minit, 1'b1);
    act <= 1'b0;
    wt(3'h2, 7, 1'b1);
    rdb(3'h6, 8'h02);
    @(posedge clk) binit <= 1'b1;
    repeat (3) @(posedge clk);
    binit <= 1'b0;
    rdb(3'h2, 8'h00);
    chk(init, 1'b0);
    @(posedge clk) ev <= 7'h01;
    @(posedge clk) ev <= 7'h00;
    rdb(3'h2, 8'h00);
    wrb(3'h0, 8'h40);
    wrb(3'h1, 8'h40);
    rdb(3'h0, 8'h00);
    chk(ndone, 9);
    end_of_test();
  end
endmodule : hdp_top_tb
